/* File: rtl/dscfg_pkg.sv */
package dscfg_pkg;
	// Register byte addresses on the APB slave (word index times four).
	localparam logic [7:0] MAIN_SETTINGS_IDX = 8'hD1;
	localparam logic [7:0] HEALTH_IDENT_IDX = 8'hD0;
	localparam logic [7:0] TRIGGER_IDX = 8'hD3;
	localparam logic [7:0] BOUND_HIGH_IDX = 8'h25;
	localparam logic [7:0] BOUND_LOW_IDX = 8'h26;
	localparam logic [7:0] CODE_OUT_IDX = 8'h21;
	localparam logic [9:0] MAIN_SETTINGS_ADDR = 10'(MAIN_SETTINGS_IDX) << 2;
	localparam logic [9:0] HEALTH_IDENT_ADDR = 10'(HEALTH_IDENT_IDX) << 2;
	localparam logic [9:0] TRIGGER_ADDR = 10'(TRIGGER_IDX) << 2;
	localparam logic [9:0] BOUND_HIGH_ADDR = 10'(BOUND_HIGH_IDX) << 2;
	localparam logic [9:0] BOUND_LOW_ADDR = 10'(BOUND_LOW_IDX) << 2;
	localparam logic [9:0] CODE_OUT_ADDR = 10'(CODE_OUT_IDX) << 2;
	// Main settings layout and reset value.
	localparam logic [15:0] MAIN_SETTINGS_RST = 16'h01F0;
	localparam int SHAPE_HI = 15;
	localparam int SHAPE_LO = 14;
	localparam int LOCK_BIT = 13;
	localparam int PMBUS_BIT = 12;
	localparam int STEP_HI = 11;
	localparam int STEP_LO = 9;
	localparam int IVL_HI = 8;
	localparam int IVL_LO = 5;
	localparam int PDN_HI = 4;
	localparam int PDN_LO = 3;
	localparam int REF_BIT = 2;
	localparam int GAIN_HI = 1;
	localparam int GAIN_LO = 0;
	// Trigger register fields.
	localparam int KEY_HI = 15;
	localparam int KEY_LO = 12;
	localparam int RUN_BIT = 8;
	localparam int RELOAD_BIT = 5;
	localparam int PROG_BIT = 4;
	localparam logic [3:0] UNLOCK_KEY = 4'h5;
	// Status layout.
	localparam int UCRC_BIT = 15;
	localparam int FCRC_BIT = 14;
	localparam int STORE_BIT = 13;
	localparam int UPD_BIT = 12;
	// Waveform shapes and interval codes.
	localparam logic [1:0] SHAPE_TRI = 2'h0;
	localparam logic [1:0] SHAPE_SAW_UP = 2'h1;
	localparam logic [1:0] SHAPE_SAW_DN = 2'h2;
	localparam logic [1:0] SHAPE_SQR = 2'h3;
	localparam logic [3:0] IVL_NO_SLEW = 4'hF;
	localparam logic [1:0] PDN_UP = 2'h0;
	// Timing at 20 MHz.
	localparam int CLK_NS = 50;
	localparam int BASE_NS = 25600;
	localparam int BASE_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int UPD_NS = 100;
	localparam int UPD_CYC = (UPD_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {DSCFG_IDLE, DSCFG_RISE, DSCFG_FALL} dscfg_dir_t;
endpackage

/* File: rtl/dscfg_top.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: Status bit 15 shows user store CRC failure.
// R2: Status bit 14 shows factory store CRC failure.
// R3: Bit 13 high during store operation; blocks code writes.
// R4: Bit 12 high during output update; blocks code writes.
// R5: Shape 00 gives triangle between bounds.
// R6: Shape 01 gives rising sawtooth, instant fall.
// R7: Shape 10 gives falling sawtooth, instant rise.
// R8: Shape 11 gives square wave, interval timed.
// R9: Writing lock bit locks; key 0101 unlocks.
// R10: Bit 12 enables PMBus mode, resets zero.
// R11: Step field maps to 1,2,3,4,6,8,16,32 LSB.
// R12: Interval field sets step time; 1111 no slew.
// R13: Power-down field selects output state.
// R14: Bit 2 selects supply or internal reference.
// R15: Gain field applies only with internal reference.
// R16: Main settings reset to 01F0h.
// R17: Host writes key 0101 into trigger bits 15-12.
// R18: Run trigger starts continuous waveform generation.
// R19: While locked, only unlock-key writes are accepted.
// R20: Host polls busy flags before code writes.
module dscfg_top
	import dscfg_pkg::*;
#(
	parameter int CODE_W = 10,
	parameter int STORE_CYC = 64,
	parameter logic [3:0] PART_ID = 4'h3, // Arbitrary value.
	parameter logic [1:0] REV_ID = 2'h1 // Arbitrary value.
)
(
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic CLK_EN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [9:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic USER_CRC_FAIL_I,
	input wire logic FACTORY_CRC_FAIL_I,
	output logic [CODE_W-1:0] CODE_O,
	output logic [1:0] OUTPUT_POWERDOWN_SEL_O,
	output logic INT_REF_EN_O,
	output logic [1:0] OUTPUT_GAIN_SEL_O,
	output logic PMBUS_MODE_O,
	output logic STORE_PROG_O,
	output logic STORE_RELOAD_O
);
	logic [15:0] main_settings;
	logic locked;
	logic waveform_run;
	logic [CODE_W-1:0] bound_high, bound_low, code;
	logic [15:0] store_cnt;
	logic [1:0] upd_cnt;
	logic [19:0] ivl_cnt;
	logic sq_high;
	logic user_store_crc_alarm, factory_store_crc_alarm;
	dscfg_dir_t dir;

	// Bus decode; every access completes in its first access cycle.
	wire acc = PSEL_I && PENABLE_I && CLK_EN_I;
	wire wr = acc && PWRITE_I;
	wire rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
	wire hit_main = PADDR_I == MAIN_SETTINGS_ADDR;
	wire hit_stat = PADDR_I == HEALTH_IDENT_ADDR;
	wire hit_trig = PADDR_I == TRIGGER_ADDR;
	wire hit_bh = PADDR_I == BOUND_HIGH_ADDR;
	wire hit_bl = PADDR_I == BOUND_LOW_ADDR;
	wire hit_code = PADDR_I == CODE_OUT_ADDR;
	wire mapped = hit_main | hit_stat | hit_trig | hit_bh | hit_bl | hit_code;
	wire key_ok = PWDATA_I[KEY_HI:KEY_LO] == UNLOCK_KEY;
	wire store_op_pending = store_cnt != '0;
	wire update_busy = upd_cnt != '0;
	// Writes are dropped while locked, and code writes while busy.
	wire wr_ok = wr && !locked; // [R19]
	wire code_blk = store_op_pending || update_busy; // [R3] [R4]
	wire wr_main = wr_ok && hit_main;
	wire wr_trig = wr_ok && hit_trig;
	wire wr_code = wr_ok && hit_code && !code_blk;
	wire unlock = wr && hit_trig && key_ok; // [R9]
	wire start_store = wr_trig && !store_op_pending
		&& (PWDATA_I[PROG_BIT] || PWDATA_I[RELOAD_BIT]);
	wire [15:0] status = {user_store_crc_alarm, factory_store_crc_alarm,
		store_op_pending, update_busy, 6'h00, PART_ID, REV_ID}; // [R1] [R2]
	wire [15:0] rd_mux = hit_main ? {main_settings[15:14], 1'b0,
		main_settings[12:0]} : hit_stat ? status : hit_trig ?
		{7'h00, waveform_run, 8'h08} : hit_bh ? 16'(bound_high) :
		hit_bl ? 16'(bound_low) : 16'h0000;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

	// Configuration fields: shape, step and interval feed the engine, the rest except the lock bit are driven to the analog side.
	wire [1:0] shape = main_settings[SHAPE_HI:SHAPE_LO];
	wire [2:0] step_sel = main_settings[STEP_HI:STEP_LO];
	wire [3:0] ivl_sel = main_settings[IVL_HI:IVL_LO];
	assign PMBUS_MODE_O = main_settings[PMBUS_BIT]; // [R10]
	assign OUTPUT_POWERDOWN_SEL_O = main_settings[PDN_HI:PDN_LO]; // [R13]
	assign INT_REF_EN_O = main_settings[REF_BIT]; // [R14]
	// Gain is forced to the lowest span when the supply is the reference.
	assign OUTPUT_GAIN_SEL_O = INT_REF_EN_O ?
		main_settings[GAIN_HI:GAIN_LO] : 2'h0; // [R15]
	assign CODE_O = code;

	// Step size table in LSB.
	wire [5:0] step = step_sel == 3'h0 ? 6'h01 : step_sel == 3'h1 ? 6'h02 :
		step_sel == 3'h2 ? 6'h03 : step_sel == 3'h3 ? 6'h04 :
		step_sel == 3'h4 ? 6'h06 : step_sel == 3'h5 ? 6'h08 :
		step_sel == 3'h6 ? 6'h10 : 6'h20; // [R11]
	// Interval: base tier times 1, 1.25, 1.5 or 1.75; codes 12-14 short.
	wire [19:0] tier = ivl_sel[3:2] == 2'h0 ? 20'(BASE_CYC) :
		ivl_sel[3:2] == 2'h1 ? 20'(BASE_CYC * 8) : 20'(BASE_CYC * 64);
	wire [19:0] ivl_len = ivl_sel == 4'hC ? 20'(240) :
		ivl_sel == 4'hD ? 20'(80) : ivl_sel == 4'hE ? 20'(80) :
		tier + ((tier >> 2) * 20'(ivl_sel[1:0])); // [R12]
	wire no_slew = ivl_sel == IVL_NO_SLEW; // [R12]
	wire tick = no_slew || ivl_cnt >= ivl_len - 20'h1;

	wire [CODE_W:0] up = {1'b0, code} + (CODE_W+1)'(step);
	wire [CODE_W:0] dn = {1'b0, code} - (CODE_W+1)'(step);
	wire at_top = no_slew || up >= {1'b0, bound_high};
	wire at_bot = no_slew || dn[CODE_W] || dn <= {1'b0, bound_low};

	// Register writes; lock set by bit 13, cleared by the key or by reset.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!NRST_I)
		begin
			main_settings <= MAIN_SETTINGS_RST; // [R16]
			locked <= 1'b0;
			bound_high <= '0;
			bound_low <= '0;
		end
		else if (CLK_EN_I)
		begin
			if (wr_main)
				main_settings <= PWDATA_I[15:0];
			if (unlock)
				locked <= 1'b0; // [R9]
			else if (wr_main && PWDATA_I[LOCK_BIT])
				locked <= 1'b1; // [R9]
			if (wr_ok && hit_bh && !code_blk)
				bound_high <= PWDATA_I[CODE_W-1:0];
			if (wr_ok && hit_bl && !code_blk)
				bound_low <= PWDATA_I[CODE_W-1:0];
		end
	end

	// Busy counters, alarm capture and read data.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!NRST_I)
		begin
			store_cnt <= '0;
			upd_cnt <= '0;
			PRDATA_O <= '0;
			user_store_crc_alarm <= 1'b0;
			factory_store_crc_alarm <= 1'b0;
			STORE_PROG_O <= 1'b0;
			STORE_RELOAD_O <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			user_store_crc_alarm <= USER_CRC_FAIL_I; // [R1]
			factory_store_crc_alarm <= FACTORY_CRC_FAIL_I; // [R2]
			STORE_PROG_O <= start_store && PWDATA_I[PROG_BIT];
			STORE_RELOAD_O <= start_store && !PWDATA_I[PROG_BIT];
			if (start_store)
				store_cnt <= 16'(STORE_CYC); // [R3]
			else if (store_op_pending)
				store_cnt <= store_cnt - 16'h1;
			if (wr_code)
				upd_cnt <= 2'(UPD_CYC); // [R4]
			else if (update_busy)
				upd_cnt <= upd_cnt - 2'h1;
			// Captured in the setup cycle, so that it stands through the
			// access phase, where the host takes it with pready.
			if (rd_setup)
				PRDATA_O <= {16'h0000, rd_mux};
		end
	end

	// Waveform engine: runs while the trigger bit is set.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!NRST_I)
		begin
			waveform_run <= 1'b0;
			code <= '0;
			dir <= DSCFG_IDLE;
			ivl_cnt <= '0;
			sq_high <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			if (wr_trig)
				waveform_run <= PWDATA_I[RUN_BIT]; // [R18]
			if (wr_code)
				code <= PWDATA_I[CODE_W-1:0];
			else if (waveform_run && dir == DSCFG_IDLE)
			begin
				code <= bound_low; // [R18]
				dir <= DSCFG_RISE;
				ivl_cnt <= '0;
			end
			else if (!waveform_run)
				dir <= DSCFG_IDLE;
			else
			begin
				ivl_cnt <= tick ? '0 : ivl_cnt + 20'h1;
				if (tick)
				begin
					unique case (shape)
						SHAPE_TRI:
						begin
							if (dir == DSCFG_RISE)
							begin
								code <= at_top ? bound_high : up[CODE_W-1:0]; // [R5]
								if (at_top)
									dir <= DSCFG_FALL;
							end
							else
							begin
								code <= at_bot ? bound_low : dn[CODE_W-1:0]; // [R5]
								if (at_bot)
									dir <= DSCFG_RISE;
							end
						end
						SHAPE_SAW_UP:
							code <= (code >= bound_high) ? bound_low :
								at_top ? bound_high : up[CODE_W-1:0]; // [R6]
						SHAPE_SAW_DN:
							code <= (code <= bound_low) ? bound_high :
								at_bot ? bound_low : dn[CODE_W-1:0]; // [R7]
						SHAPE_SQR:
						begin
							sq_high <= !sq_high;
							code <= sq_high ? bound_low : bound_high; // [R8]
						end
					endcase
				end
			end
		end
	end

	// Checks on the register behaviour.
	chk_reset_value: assert property (@(posedge SYS_CLK_I) // [R16]
		!NRST_I |=> main_settings == MAIN_SETTINGS_RST)
		else $error("main settings reset value wrong");
	chk_lock_blocks: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		locked && wr && hit_main && CLK_EN_I |=> $stable(main_settings)) // [R19]
		else $error("write accepted while locked");
	chk_unlock_key: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I && unlock |=> !locked) // [R9]
		else $error("key did not unlock");
	chk_lock_set: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I && wr_main && PWDATA_I[LOCK_BIT] && !unlock |=> locked) // [R9]
		else $error("lock bit did not lock");
	chk_store_busy: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I && start_store |=> status[STORE_BIT]) // [R3]
		else $error("store busy not raised");
	chk_update_busy: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I && wr_code |=> status[UPD_BIT]
		&& code == $past(PWDATA_I[CODE_W-1:0])) // [R4]
		else $error("update busy or code wrong");
	chk_code_hold: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		code_blk && !waveform_run && CLK_EN_I |=> $stable(code)) // [R4]
		else $error("code changed while busy");
	chk_gain_gate: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		!INT_REF_EN_O |-> OUTPUT_GAIN_SEL_O == 2'h0) // [R15]
		else $error("gain active without internal reference");
	chk_crc_alarm: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I ##1 CLK_EN_I |-> status[UCRC_BIT] == $past(USER_CRC_FAIL_I)
		&& status[FCRC_BIT] == $past(FACTORY_CRC_FAIL_I)) // [R1] [R2]
		else $error("crc alarm mismatch");
	chk_square_bounds: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		CLK_EN_I && waveform_run && shape == SHAPE_SQR && tick && dir != DSCFG_IDLE
		&& !wr_code |=> code == bound_high || code == bound_low) // [R8]
		else $error("square wave off bounds");
endmodule
`default_nettype wire

/* File: sim/dscfg_host.sv */
`timescale 1ns/10ps
`default_nettype none
// APB host that stands in for the serial target issuing register accesses.
module dscfg_host
(
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [9:0] paddr,
	output logic [31:0] pwdata
);
	logic err;
	// Idle bus at time zero.
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h00000000;
	end
	// Call right after a rising edge; returns one edge after the access edge.
	// Released address and data are inverted so no stale value lingers.
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the bench watchdog ends a wait for pready.
		while (pready !== 1'b1)
			@(posedge clk);
		err = pslverr;
		q = prdata; // Read data stands through the access phase.
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask
	// Key 0101 goes into trigger bits 15-12 to drop the lock.
	task automatic unlock();
		logic [31:0] q;
		xfer(1'b1, dscfg_pkg::TRIGGER_ADDR, 32'h00005000, q);
	endtask
	// Both busy flags must read zero before converter data or bounds writes.
	task automatic wait_idle();
		logic [31:0] q;
		q = 32'hFFFFFFFF;
		while (q[13:12] !== 2'h0)
			xfer(1'b0, dscfg_pkg::HEALTH_IDENT_ADDR, 32'h0, q);
	endtask
endmodule
`default_nettype wire

/* File: sim/test_dac_status_and_general_config.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED %0t value mismatch", $time); end end
module test_dac_status_and_general_config
	import dscfg_pkg::*;
;
	localparam logic [3:0] PID = 4'hA; // Arbitrary value.
	localparam logic [1:0] RID = 2'h2; // Arbitrary value.
	localparam logic [9:0] LO = 10'd100;
	localparam logic [9:0] HI = 10'd140;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ucrc = 1'b0;
	logic fcrc = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [9:0] code, prev;
	logic [1:0] pdn, gain;
	logic iref, pmb;
	logic [31:0] seed = 32'd43570;
	logic [15:0] v;
	int n_tests = 0;
	int n_mismatch = 0;
	int moves;
	dscfg_top #(.STORE_CYC(40), .PART_ID(PID), .REV_ID(RID)) dut (
		.SYS_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(1'b1), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .USER_CRC_FAIL_I(ucrc),
		.FACTORY_CRC_FAIL_I(fcrc), .CODE_O(code),
		.OUTPUT_POWERDOWN_SEL_O(pdn), .INT_REF_EN_O(iref),
		.OUTPUT_GAIN_SEL_O(gain), .PMBUS_MODE_O(pmb), .STORE_PROG_O(),
		.STORE_RELOAD_O());
	dscfg_host host (.clk(clk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	// Half-period toggle gives 50 ns.
	always #25 clk = ~clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Legal next code for a running waveform of the given shape.
	function automatic logic ok(logic [1:0] s, logic [9:0] p, logic [9:0] c);
		if (c < LO || c > HI)
			return 1'b0;
		case (s)
			SHAPE_SAW_UP: return c >= p || c == LO;
			SHAPE_SAW_DN: return c <= p || c == HI;
			SHAPE_SQR: return c == LO || c == HI;
			default: return 1'b1;
		endcase
	endfunction
	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
	// Main sequence.
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		host.xfer(1'b0, MAIN_SETTINGS_ADDR, 32'h0, q);
		`CHK(q, 32'h000001F0)
		`CHK({pdn, iref, gain, pmb}, 6'h20)
		for (int i = 0; i < 4; i++)
		begin
			ucrc <= i[0];
			fcrc <= i[1];
			// One edge lets the alarm flops take the new levels first.
			@(posedge clk);
			host.xfer(1'b0, HEALTH_IDENT_ADDR, 32'h0, q);
			`CHK(q[15:0], {i[0], i[1], 8'h00, PID, RID})
		end
		for (int i = 0; i < 8; i++)
		begin
			q = xs();
			v = q[15:0];
			v[15:9] = {i[1:0], 1'b0, v[12], i[2:0]};
			v[2] = i[2];
			host.xfer(1'b1, MAIN_SETTINGS_ADDR, {16'h0, v}, q);
			host.xfer(1'b0, MAIN_SETTINGS_ADDR, 32'h0, q);
			`CHK(q, {16'h0, v})
			`CHK({pdn, iref, pmb}, {v[4:2], v[12]})
			`CHK(gain, v[2] ? v[1:0] : 2'h0)
		end
		host.xfer(1'b1, MAIN_SETTINGS_ADDR, 32'h4, q);
		host.xfer(1'b1, MAIN_SETTINGS_ADDR, 32'h2004, q);
		host.xfer(1'b1, MAIN_SETTINGS_ADDR, 32'h8, q);
		host.xfer(1'b0, MAIN_SETTINGS_ADDR, 32'h0, q);
		`CHK(q, 32'h4)
		host.unlock();
		host.xfer(1'b1, MAIN_SETTINGS_ADDR, 32'h8, q);
		host.xfer(1'b0, MAIN_SETTINGS_ADDR, 32'h0, q);
		`CHK(q, 32'h8)
		host.xfer(1'b1, TRIGGER_ADDR, 32'h10, q);
		host.xfer(1'b1, CODE_OUT_ADDR, 32'h3FC, q);
		`CHK(code, 10'h000)
		host.xfer(1'b0, HEALTH_IDENT_ADDR, 32'h0, q);
		`CHK(q[13], 1'b1)
		host.wait_idle();
		host.xfer(1'b1, CODE_OUT_ADDR, 32'h3FC, q);
		`CHK(code, 10'h3FC)
		host.xfer(1'b0, 10'h3FC, 32'h0, q);
		`CHK({host.err, q}, 33'h100000000)
		host.xfer(1'b1, BOUND_HIGH_ADDR, {22'h0, HI}, q);
		host.xfer(1'b1, BOUND_LOW_ADDR, {22'h0, LO}, q);
		for (int s = 0; s < 4; s++)
		begin
			host.xfer(1'b1, MAIN_SETTINGS_ADDR, {16'h0, s[1:0], 14'h0FE0}, q);
			host.xfer(1'b1, TRIGGER_ADDR, 32'h100, q);
			#1 prev = code;
			moves = 0;
			repeat (30)
			begin
				@(posedge clk);
				#1;
				`CHK(ok(s[1:0], prev, code), 1'b1)
				moves += int'(code != prev);
				prev = code;
			end
			`CHK(moves > 0, 1'b1)
			@(posedge clk);
			host.xfer(1'b1, TRIGGER_ADDR, 32'h0, q);
		end
		// Triangle, 6 LSB steps, interval code 1110 (80 cycles a step).
		host.xfer(1'b1, MAIN_SETTINGS_ADDR, 32'h000009C0, q);
		host.xfer(1'b1, TRIGGER_ADDR, 32'h100, q);
		repeat (40) @(posedge clk);
		#1;
		`CHK(code, LO)
		repeat (60) @(posedge clk);
		#1;
		`CHK(code, LO + 10'd6)
		@(posedge clk);
		host.xfer(1'b1, TRIGGER_ADDR, 32'h0, q);
		conclude();
	end
endmodule
`default_nettype wire
